// file: common/tmc_pkg.sv
`default_nettype none
package tmc_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_CLKSEL = 8'h08;
    localparam logic [7:0] OFS_CMP1 = 8'h0c;
    localparam logic [7:0] OFS_CMP2 = 8'h10;
    localparam logic [7:0] OFS_ACT1 = 8'h14;
    localparam logic [7:0] OFS_ACT2 = 8'h18;
    localparam logic [7:0] OFS_CAPT = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    // Mode codes
    localparam logic [3:0] MODE_FREE = 4'hf;
    localparam logic [3:0] MODE_EXT_TRIG = 4'he;
    localparam logic [3:0] MODE_INT_RST = 4'hd;
    localparam logic [3:0] MODE_FREE_PASS = 4'hc;
    localparam logic [3:0] MODE_EXT_PASS = 4'hb;
    localparam logic [3:0] MODE_RST = 4'hf;
    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_OUTINIT = 1;
    localparam int CTRL_EIM = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // Clock select: bit 0 external source, bits 2:1 edge (01 rise, 10 fall, 11 both)
    localparam int CSEL_EXT = 0;
    localparam int CSEL_EDGE_LO = 1;
    localparam logic [2:0] CSEL_RST = 3'h0;
    // Compare action fields
    localparam int ACT_RST = 0;
    localparam int ACT_IRQ = 1;
    localparam int ACT_TOG = 2;
    localparam int ACT_SINGLE = 3;
    localparam logic [3:0] ACT_RST_VAL = 4'h0;
    localparam logic [7:0] CMP_RST_VAL = 8'hff;
    // Status fields: bit 0 run, sticky flags above it
    localparam int STAT_RUN = 0;
    localparam int STAT_CM1 = 1;
    localparam int STAT_CM2 = 2;
    localparam int STAT_EDGE = 3;

    typedef enum logic [1:0] {TMC_IDLE, TMC_WAIT_TRIG, TMC_COUNT} tmc_phase_e;

    function automatic logic tmc_is_trig_mode(input logic [3:0] m);
        return (m == MODE_EXT_TRIG) || (m == MODE_EXT_PASS);
    endfunction : tmc_is_trig_mode

    function automatic logic tmc_is_pass_mode(input logic [3:0] m);
        return (m == MODE_FREE_PASS) || (m == MODE_EXT_PASS);
    endfunction : tmc_is_pass_mode

    function automatic logic tmc_is_known_mode(input logic [3:0] m);
        return (m >= MODE_EXT_PASS);
    endfunction : tmc_is_known_mode
endpackage : tmc_pkg
`default_nettype wire

// file: common/tmc_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmc_core_if;
    logic pinLevel;
    logic [1:0] edgeSel;
    logic edgeSeen;
    logic tick;
    logic rearm;
    logic [7:0] count;
    logic [7:0] cmp1;
    logic [7:0] cmp2;
    logic single1;
    logic single2;
    logic match1;
    logic match2;
    logic useSecond;
    modport edgeSide(input pinLevel, edgeSel, output edgeSeen);
    modport cmpSide(input tick, rearm, count, cmp1, cmp2, single1, single2,
                    output match1, match2, useSecond);
endinterface : tmc_core_if
`default_nettype wire

// file: rtl/tmc_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_edge_det (
    input wire logic clk_sys, // System clock
    input wire logic nrst,    // Async reset, active low
    input wire logic ce,      // Clock enable
    tmc_core_if.edgeSide ifc  // Pin level in, edge pulse out
);
    import tmc_pkg::*;
    logic pinNow;
    logic pinPrev;

    // Sampled on the system clock only, so a stopped oscillator silences the input
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pinNow <= 1'b0;
            pinPrev <= 1'b0;
        end else if (ce) begin
            pinNow <= ifc.pinLevel;
            pinPrev <= pinNow;
        end
    end

    wire rise = pinNow & ~pinPrev;
    wire fall = ~pinNow & pinPrev;
    assign ifc.edgeSeen = (rise & ifc.edgeSel[0]) | (fall & ifc.edgeSel[1]);

    a_edge_needs_sel: assert property (@(posedge clk_sys) disable iff (!nrst)
        ifc.edgeSeen |-> (ifc.edgeSel != 2'b00))
        else $error("edge reported with no edge selected");
endmodule : tmc_edge_det
`default_nettype wire

// file: rtl/tmc_cmp_seq.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_cmp_seq (
    input wire logic clk_sys, // System clock
    input wire logic nrst,    // Async reset, active low
    input wire logic ce,      // Clock enable
    tmc_core_if.cmpSide ifc   // Compare values in, match pulses out
);
    import tmc_pkg::*;
    logic sel2;
    logic done1;
    logic done2;

    // Match on the count tick that leaves value x: x+1 ticks from zero
    assign ifc.match1 = ifc.tick && !sel2 && !done1 && (ifc.count == ifc.cmp1);
    assign ifc.match2 = ifc.tick && sel2 && !done2 && (ifc.count == ifc.cmp2);
    assign ifc.useSecond = sel2;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel2 <= 1'b0;
            done1 <= 1'b0;
            done2 <= 1'b0;
        end else if (ce) begin
            if (ifc.rearm) begin
                sel2 <= 1'b0;
                done1 <= 1'b0;
                done2 <= 1'b0;
            end else if (ifc.match1) begin
                done1 <= ifc.single1;
                sel2 <= !done2;
            end else if (ifc.match2) begin
                done2 <= ifc.single2;
                sel2 <= done1;
            end
        end
    end

    sequence s_single1_hit;
        ifc.match1 && ifc.single1;
    endsequence
    sequence s_quiet;
        (!ifc.rearm && ce) [*8];
    endsequence

    a_single_once: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_single1_hit ##1 s_quiet |-> !ifc.match1)
        else $error("single-action compare fired twice");
    a_alt_to_second: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        ifc.match1 && !done2 && !ifc.rearm |=> ifc.useSecond)
        else $error("selector did not move to second compare");
    a_alt_to_first: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        ifc.match2 && !done1 && !ifc.rearm |=> !ifc.useSecond)
        else $error("selector did not return to first compare");
    a_single_sticks: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        ifc.match1 && ifc.single1 && !ifc.rearm |=> ifc.useSecond [*2])
        else $error("single first compare still selected");
endmodule : tmc_cmp_seq
`default_nettype wire

// file: rtl/tmc_timer_top.sv
// Contract
// - 8-bit up-counter, two compares, one capture
// - Input pin sampled by system clock
// - Capture register shows running count in basic modes
// - Trigger operation idles until input edge
// - Single-action match fires once per start
// - Match resets, interrupts or toggles per mask
// - Compares alternate first, second, first
// - Single-action one means other compare only
// - Control holds run, initial level, edge mask
// - Clock select picks source and edge
// - Edge interrupt only when masked in, stopped
// - Status shows run, matches, edge detects
// - Compare value x matches after x+1
// - Basic mode counts every selected clock
// - External trigger mode waits first edge
// - Later edges capture, clear and restart
// - Trigger edges re-arm single actions
// - Companion toggle captures and clears counter
// - Companion toggle re-arms single actions
// - Mode 4 is basic with companion output
// - Mode 5 is trigger with companion output
// - Mode register selects timer modes
// - Mode codes 1111 to 1011, reset 1111
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_top (
    input wire logic clk_sys,                         // 40 MHz system clock
    input wire logic nrst,                            // Async reset, active low
    input wire logic ce,                              // Clock enable, freezes all state
    input wire logic psel,                            // APB select
    input wire logic penable,                         // APB enable
    input wire logic pwrite,                          // APB write
    input wire logic [tmc_pkg::ADDR_W-1:0] paddr,     // APB byte address
    input wire logic [31:0] pwdata,                   // APB write data
    output logic [31:0] prdata,                       // APB read data
    output logic pready,                              // APB ready
    output logic pslverr,                             // APB error on unmapped address
    input wire logic timerInputPin,                   // External timer input
    input wire logic intTick,                         // Internal count clock enable
    input wire logic companionToggle,                 // Companion timer toggle pulse
    input wire logic companionOutput,                 // Companion timer output level
    output logic timerOutputPin,                      // Timer output pin
    output logic irqReq                               // Timer interrupt request pulse
);
    import tmc_pkg::*;

    logic [3:0] modeSel;
    logic [2:0] ctrl;
    logic [2:0] clkSel;
    logic [7:0] cmp1;
    logic [7:0] cmp2;
    logic [3:0] act1;
    logic [3:0] act2;
    logic [7:0] capture;
    logic [2:0] statFlags;
    logic [7:0] count;
    logic outFf;
    tmc_phase_e phase;

    tmc_core_if coreIf();

    // APB decode
    wire apbAcc = psel && penable;
    wire apbDone = apbAcc && pready;
    wire wrEn = apbDone && pwrite;
    wire hitMode = (paddr == OFS_MODE);
    wire hitCtrl = (paddr == OFS_CTRL);
    wire hitClk = (paddr == OFS_CLKSEL);
    wire hitCmp1 = (paddr == OFS_CMP1);
    wire hitCmp2 = (paddr == OFS_CMP2);
    wire hitAct1 = (paddr == OFS_ACT1);
    wire hitAct2 = (paddr == OFS_ACT2);
    wire hitCapt = (paddr == OFS_CAPT);
    wire hitStat = (paddr == OFS_STAT);
    wire addrHit = hitMode | hitCtrl | hitClk | hitCmp1 | hitCmp2 | hitAct1 | hitAct2
                   | hitCapt | hitStat;
    wire [31:0] rdMux = hitMode ? {28'h0, modeSel} :
                        hitCtrl ? {29'h0, ctrl} :
                        hitClk ? {29'h0, clkSel} :
                        hitCmp1 ? {24'h0, cmp1} :
                        hitCmp2 ? {24'h0, cmp2} :
                        hitAct1 ? {28'h0, act1} :
                        hitAct2 ? {28'h0, act2} :
                        hitCapt ? {24'h0, capture} :
                        hitStat ? {28'h0, statFlags, ctrl[CTRL_RUN]} : 32'h0;
    wire [2:0] statClr = (wrEn && hitStat) ? pwdata[3:1] : 3'h0;

    // Mode decode
    wire runBit = ctrl[CTRL_RUN];
    wire trigMode = tmc_is_trig_mode(modeSel);
    wire intRstMode = (modeSel == MODE_INT_RST);
    wire passMode = tmc_is_pass_mode(modeSel);
    wire knownMode = tmc_is_known_mode(modeSel);
    wire edgeSeen = coreIf.edgeSeen;

    // Trigger modes count the internal clock only
    wire tick = (clkSel[CSEL_EXT] && !trigMode) ? edgeSeen : intTick;
    wire inCount = (phase == TMC_COUNT);
    wire starting = (phase == TMC_IDLE) && runBit && knownMode;
    wire trigStart = (phase == TMC_WAIT_TRIG) && edgeSeen;
    wire trigRestart = inCount && trigMode && edgeSeen;
    wire intRestart = inCount && intRstMode && companionToggle;
    wire restart = trigRestart || intRestart;
    wire rearm = starting || trigStart || restart;
    wire countTick = inCount && tick && !restart;

    wire m1 = coreIf.match1;
    wire m2 = coreIf.match2;
    wire resetHit = (m1 && act1[ACT_RST]) || (m2 && act2[ACT_RST]);
    wire irqHit = (m1 && act1[ACT_IRQ]) || (m2 && act2[ACT_IRQ]);
    wire togHit = (m1 && act1[ACT_TOG]) || (m2 && act2[ACT_TOG]);
    wire edgeIrq = edgeSeen && ctrl[CTRL_EIM] && !runBit;

    // Natural 8-bit overflow gives the wrap when no compare reset is armed
    wire [7:0] countInc = count + 8'h01;
    wire [7:0] next_count = (starting || restart || resetHit) ? 8'h00 :
                            countTick ? countInc : count;
    wire next_outFf = (phase == TMC_IDLE) ? ctrl[CTRL_OUTINIT] :
                      togHit ? !outFf : outFf;
    wire [2:0] statSet = {edgeSeen, m2, m1};

    assign coreIf.pinLevel = timerInputPin;
    assign coreIf.edgeSel = clkSel[CSEL_EDGE_LO +: 2];
    assign coreIf.tick = countTick;
    assign coreIf.rearm = rearm;
    assign coreIf.count = count;
    assign coreIf.cmp1 = cmp1;
    assign coreIf.cmp2 = cmp2;
    assign coreIf.single1 = act1[ACT_SINGLE];
    assign coreIf.single2 = act2[ACT_SINGLE];

    tmc_edge_det uEdge (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .ifc(coreIf.edgeSide)
    );

    tmc_cmp_seq uCmp (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .ifc(coreIf.cmpSide)
    );

    // APB slave: one wait state, so every access phase lasts two cycles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= apbAcc && !pready;
            pslverr <= apbAcc && !pready && !addrHit;
            if (apbAcc && !pready) begin
                prdata <= rdMux;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            modeSel <= MODE_RST;
            ctrl <= CTRL_RST;
            clkSel <= CSEL_RST;
            cmp1 <= CMP_RST_VAL;
            cmp2 <= CMP_RST_VAL;
            act1 <= ACT_RST_VAL;
            act2 <= ACT_RST_VAL;
        end else if (ce && wrEn) begin
            if (hitMode) begin
                modeSel <= pwdata[3:0];
            end
            if (hitCtrl) begin
                ctrl <= pwdata[2:0];
            end
            if (hitClk) begin
                clkSel <= pwdata[2:0];
            end
            if (hitCmp1) begin
                cmp1 <= pwdata[7:0];
            end
            if (hitCmp2) begin
                cmp2 <= pwdata[7:0];
            end
            if (hitAct1) begin
                act1 <= pwdata[3:0];
            end
            if (hitAct2) begin
                act2 <= pwdata[3:0];
            end
        end
    end

    // Sticky flags: a new event beats a write-one clear in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            statFlags <= 3'h0;
        end else if (ce) begin
            statFlags <= statSet | (statFlags & ~statClr);
        end
    end

    // Counter phase
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase <= TMC_IDLE;
        end else if (ce) begin
            if (!runBit || !knownMode) begin
                phase <= TMC_IDLE;
            end else begin
                unique case (phase)
                    TMC_IDLE: phase <= trigMode ? TMC_WAIT_TRIG : TMC_COUNT;
                    TMC_WAIT_TRIG: phase <= edgeSeen ? TMC_COUNT : TMC_WAIT_TRIG;
                    TMC_COUNT: phase <= TMC_COUNT;
                endcase
            end
        end
    end

    // Counter, capture and output stage
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= 8'h00;
            capture <= 8'h00;
            outFf <= 1'b0;
            timerOutputPin <= 1'b0;
            irqReq <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            if (restart) begin
                capture <= count;
            end else if (!trigMode && !intRstMode) begin
                capture <= count;
            end
            outFf <= next_outFf;
            timerOutputPin <= passMode ? companionOutput : outFf;
            irqReq <= irqHit || edgeIrq;
        end
    end

    sequence s_trig_edge;
        inCount && trigMode && edgeSeen;
    endsequence
    sequence s_cleared_with_capture;
        (count == 8'h00) && (capture == $past(count));
    endsequence

    a_wait_holds: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        (phase == TMC_WAIT_TRIG) && !edgeSeen && runBit |=> (count == 8'h00))
        else $error("counter moved while waiting for trigger");
    a_trig_restart: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        s_trig_edge |=> s_cleared_with_capture)
        else $error("trigger edge did not capture and clear");
    a_int_restart: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        intRestart |=> s_cleared_with_capture)
        else $error("companion toggle did not capture and clear");
    a_match_reset: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        resetHit |=> (count == 8'h00))
        else $error("compare reset did not clear counter");
    a_count_step: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        countTick && !resetHit |=> (count == $past(count) + 8'h01))
        else $error("counter did not step by one");
    a_edge_irq: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        edgeSeen && runBit && !irqHit |=> !irqReq)
        else $error("edge interrupt raised while running");
    a_pass_out: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        passMode [*2] |-> (timerOutputPin == $past(companionOutput)))
        else $error("output pin not following companion output");
    a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        m1 && statClr[0] |=> statFlags[0])
        else $error("compare flag lost against clear");
    a_run_idle_out: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        (phase == TMC_IDLE) |=> (outFf == $past(ctrl[CTRL_OUTINIT])))
        else $error("output level not preset while stopped");
endmodule : tmc_timer_top
`default_nettype wire

// file: verif/tmc_companion_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_companion_model (
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic run, // Companion counting
    input wire logic [7:0] period, // Cycles between toggles
    output logic companionToggle, // One-cycle toggle pulse
    output logic companionOutput // Companion output level
);
    logic [7:0] cnt;
    wire logic wrapNow = (cnt == period - 8'h01);
    // Stands still while stopped, as the real companion does
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            companionToggle <= 1'b0;
            companionOutput <= 1'b0;
        end else if (run) begin
            cnt <= wrapNow ? 8'h00 : cnt + 8'h01;
            companionToggle <= wrapNow;
            companionOutput <= companionOutput ^ wrapNow;
        end else begin
            companionToggle <= 1'b0;
        end
    end
endmodule : tmc_companion_model
`default_nettype wire

// file: verif/tb_eight_bit_timer_counter_modes.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eight_bit_timer_counter_modes;
    import tmc_pkg::*;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, pin, tick, tog, cout, pinOut, irq;
    logic compRun;
    logic [7:0] paddr, compPeriod;
    logic [31:0] pwdata, prdata, rv;
    int errCount, compares;

    tmc_timer_top i_tmc_timer_top (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timerInputPin(pin), .intTick(tick),
        .companionToggle(tog), .companionOutput(cout), .timerOutputPin(pinOut), .irqReq(irq));
    tmc_companion_model i_tmc_companion_model (.clk_sys(clk_sys), .nrst(nrst), .run(compRun),
        .period(compPeriod), .companionToggle(tog), .companionOutput(cout));

    task automatic test_done();
        $display("errors %0d compares %0d", errCount, compares);
        if (errCount == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // Read data and error are taken at the edge that saw pready high
        if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end else begin
            errCount++;
            test_done();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, r, exp);
    endtask : rdchk
    // Counts edges until the next interrupt pulse, or gives up at lim
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (irq !== 1'b1 && n < lim);
        // A missing interrupt is a hang, not a value to compare
        if (irq !== 1'b1) begin
            errCount++;
            test_done();
        end
    endtask : wait_irq
    task automatic gaps(input string name, input int g0, input int g1);
        int n;
        wait_irq(300, n);
        wait_irq(300, n);
        chk(name, n, g0);
        wait_irq(300, n);
        chk(name, n, g1);
    endtask : gaps
    task automatic pulse(output logic seen);
        seen = 1'b0;
        pin <= 1'b1;
        repeat (3) begin
            @(posedge clk_sys);
            if (irq === 1'b1) seen = 1'b1;
        end
        pin <= 1'b0;
        repeat (3) begin
            @(posedge clk_sys);
            if (irq === 1'b1) seen = 1'b1;
        end
    endtask : pulse
    task automatic stop_all();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_STAT, 32'he);
        wr(OFS_MODE, 32'hf);
    endtask : stop_all
    task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [3:0] a1,
                       input logic [3:0] a2);
        wr(OFS_CMP1, {24'h0, c1});
        wr(OFS_CMP2, {24'h0, c2});
        wr(OFS_ACT1, {28'h0, a1});
        wr(OFS_ACT2, {28'h0, a2});
    endtask : cfg

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdchk("mode", OFS_MODE, 32'hf);
        rdchk("ctrl", OFS_CTRL, 32'h0);
        rdchk("clksel", OFS_CLKSEL, 32'h0);
        rdchk("cmp1", OFS_CMP1, 32'hff);
        rdchk("cmp2", OFS_CMP2, 32'hff);
        rdchk("act", OFS_ACT1, 32'h0);
        rdchk("stat", OFS_STAT, 32'h0);
        wr(OFS_CAPT, 32'h55);
        rdchk("capt ro", OFS_CAPT, 32'h0);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
    endtask : t_reset
    task automatic t_alternate();
        cfg(8'h02, 8'h04, 4'h3, 4'h3);
        wr(OFS_CTRL, 32'h1);
        gaps("alt gap", 5, 3);
        rdchk("stat flags", OFS_STAT, 32'h7);
        stop_all();
        rdchk("stat clr", OFS_STAT, 32'h0);
        cfg(8'h02, 8'h04, 4'hb, 4'h3);
        wr(OFS_CTRL, 32'h1);
        gaps("single gap", 5, 5);
        stop_all();
    endtask : t_alternate
    task automatic t_toggle();
        int n;
        logic lv;
        wr(OFS_CTRL, 32'h2);
        repeat (3) @(posedge clk_sys);
        chk("init level", {31'h0, pinOut}, 32'h1);
        cfg(8'h03, 8'h03, 4'h5, 4'h5);
        wr(OFS_CTRL, 32'h3);
        repeat (3) begin
            lv = pinOut;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (pinOut === lv && n < 50);
            if (pinOut === lv) begin
                errCount++;
                test_done();
            end
        end
        chk("toggle gap", n, 4);
        stop_all();
    endtask : t_toggle
    task automatic t_wrap();
        logic [31:0] a;
        logic [31:0] b;
        logic e;
        cfg(8'hff, 8'hff, 4'h2, 4'h2);
        wr(OFS_CTRL, 32'h1);
        gaps("wrap gap", 256, 256);
        apb(1'b0, OFS_CAPT, 32'h0, a, e);
        apb(1'b0, OFS_CAPT, 32'h0, b, e);
        chk("capt running", {24'h0, b[7:0] - a[7:0]}, 32'h4);
        stop_all();
    endtask : t_wrap
    task automatic t_edges();
        logic s0, s1, s2;
        cfg(8'h02, 8'h02, 4'h3, 4'h3);
        wr(OFS_CLKSEL, 32'h3);
        tick <= 1'b0;
        wr(OFS_CTRL, 32'h1);
        pulse(s0);
        pulse(s1);
        pulse(s2);
        chk("ext count", {29'h0, s0, s1, s2}, 32'h1);
        stop_all();
        tick <= 1'b1;
        cfg(8'hff, 8'hff, 4'h0, 4'h0);
        wr(OFS_CLKSEL, 32'h2);
        wr(OFS_CTRL, 32'h4);
        pulse(s0);
        rdchk("edge flag", OFS_STAT, 32'h8);
        wr(OFS_CTRL, 32'h0);
        pulse(s1);
        wr(OFS_CTRL, 32'h5);
        pulse(s2);
        chk("edge irq", {29'h0, s0, s1, s2}, 32'h4);
        stop_all();
    endtask : t_edges
    task automatic t_trigger(input logic [3:0] m);
        int n;
        logic s;
        cfg(8'h03, 8'hff, 4'h2, 4'h0);
        wr(OFS_MODE, {28'h0, m});
        wr(OFS_CLKSEL, 32'h2);
        wr(OFS_CTRL, 32'h1);
        // A free-running counter would hit compare 3 well inside this window
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            if (irq !== 1'b0) n++;
        end
        chk("trig idle", n, 0);
        pulse(s);
        repeat (10) @(posedge clk_sys);
        pulse(s);
        rdchk("trig capt", OFS_CAPT, 32'hf);
        pulse(s);
        repeat (4) @(posedge clk_sys);
        pulse(s);
        rdchk("trig restart", OFS_CAPT, 32'h9);
        stop_all();
    endtask : t_trigger
    task automatic t_passthru(input logic [3:0] m);
        logic prev;
        wr(OFS_MODE, {28'h0, m});
        repeat (3) @(posedge clk_sys);
        prev = cout;
        repeat (20) begin
            @(posedge clk_sys);
            chk("pass pin", {31'h0, pinOut}, {31'h0, prev});
            prev = cout;
        end
        stop_all();
    endtask : t_passthru
    task automatic t_intrst();
        compPeriod <= 8'd12;
        wr(OFS_MODE, {28'h0, MODE_INT_RST});
        wr(OFS_CTRL, 32'h1);
        repeat (40) @(posedge clk_sys);
        rdchk("int capt", OFS_CAPT, 32'hb);
        stop_all();
    endtask : t_intrst

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, pin} = 4'h0;
        tick = 1'b1;
        compRun = 1'b1;
        compPeriod = 8'd5;
        paddr = 8'h0;
        pwdata = 32'h0;
        errCount = 0;
        compares = 0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_alternate();
        t_toggle();
        t_wrap();
        t_edges();
        t_trigger(MODE_EXT_TRIG);
        t_trigger(MODE_EXT_PASS);
        t_passthru(MODE_FREE_PASS);
        t_passthru(MODE_EXT_PASS);
        t_intrst();
        test_done();
    end
endmodule : tb_eight_bit_timer_counter_modes
`default_nettype wire
